// ===== logic/tsf_regs.svh
// Register offsets, bit positions and reset values for the trap status block
`ifndef TSF_REGS_SVH
`define TSF_REGS_SVH
`define TSF_STATUS_OFFSET 12'h000
`define TSF_ALIGN_CTL_OFFSET 12'h004
`define TSF_BIT_UNUSED 0
`define TSF_BIT_OSC 1
`define TSF_BIT_STACK 2
`define TSF_BIT_ADDR 3
`define TSF_BIT_MATH 4
`define TSF_BIT_DMA 5
`define TSF_BIT_DIV0 6
`define TSF_FLAG_LO 1
`define TSF_FLAG_HI 6
`define TSF_STATUS_RESET 16'h0000
`define TSF_ALIGN_CTL_RESET 1'b1
`define TSF_RESP_OKAY 2'h0
`define TSF_RESP_SLVERR 2'h2
`endif

// ===== logic/tsf_pkg.sv
// Types shared by the trap status block
package tsf_pkg;
  typedef logic [15:0] tsf_word_t;
  typedef enum logic [1:0] {
    TSF_RD_IDLE = 2'b00,
    TSF_RD_RESP = 2'b01
  } tsf_rd_state_t;
endpackage

// ===== logic/tsf_align_check.sv
// Misaligned word access detector for the core data path
`timescale 1ns/1ps
`default_nettype none
module tsf_align_check
(
  input wire logic enable_i,    // Check enabled
  input wire logic valid_i,     // Access presented
  input wire logic word_i,      // Word (not byte) access
  input wire logic write_i,     // Access is a write
  input wire logic addr_lsb_i,  // Address bit 0
  output logic misaligned_o,    // Odd word address seen
  output logic write_allow_o    // Write may reach memory
);
  // Only word accesses need an even address; bytes may be odd
  assign misaligned_o = enable_i & valid_i & word_i & addr_lsb_i;
  // A faulting write still retires but never touches memory
  assign write_allow_o = valid_i & write_i & ~misaligned_o;
endmodule
`default_nettype wire

// ===== logic/tsf_top.sv
// Trap status flags register with AXI4-Lite access and alignment checking
// Register map, one aligned 32-bit word per register
//   0x000 trap status: flags in bits 6..1, every other bit reads zero
//   0x004 alignment check enable in bit 0, on after reset
//
// Clearing
//   A zero written to a flag clears it, a one leaves it alone, so
//   software can clear one flag without racing a trap on another
//   Only byte lane 0 acts; writes on the upper lanes are ignored
//   A trap in its own clearing cycle is kept rather than lost
//
// Register bus timing
//   Address and data may arrive in either order
//   Write answer one cycle after the second half is taken
//   Read answer one cycle after the address is taken
//   Unmapped offsets answer with a slave error and read as zero
//
// Limitations
//   One write and one read in flight at a time
//   A trap source held high sets its flag again every cycle
//   Divide cause is ignored unless a math trap comes with it
//   Read faults raise the address flag but gate nothing
//   Turning the check off lets odd word writes reach memory
//   All sources share the system clock, so nothing is synchronised
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tsf_regs.svh"
module tsf_top
(
  input wire logic CLK_SYS_I,             // System clock 250 MHz
  input wire logic RST_I,                 // Async reset, high
  input wire logic TRAP_MATH_I,           // Math trap pulse
  input wire logic TRAP_DIV0_I,           // Math trap cause is divide by zero
  input wire logic TRAP_DMA_I,            // DMA controller trap pulse
  input wire logic TRAP_STACK_I,          // Stack trap pulse
  input wire logic TRAP_OSC_I,            // Oscillator failure trap pulse
  input wire logic TRAP_ADDR_I,           // Other address trap pulse
  input wire logic MEM_VALID_I,           // Core access valid
  input wire logic MEM_WORD_I,            // Core access is word wide
  input wire logic MEM_WRITE_I,           // Core access is a write
  input wire logic [15:0] MEM_ADDR_I,     // Core effective address
  output logic MEM_WRITE_EN_O,            // Write strobe to memory
  output logic ADDR_FAULT_O,              // Misaligned access seen
  output logic [15:0] STATUS_O,           // Current flag word
  input wire logic [11:0] S_AXI_AWADDR,   // Write address
  input wire logic S_AXI_AWVALID,         // Write address valid
  output logic S_AXI_AWREADY,             // Write address ready
  input wire logic [31:0] S_AXI_WDATA,    // Write data
  input wire logic [3:0] S_AXI_WSTRB,     // Write strobes
  input wire logic S_AXI_WVALID,          // Write data valid
  output logic S_AXI_WREADY,              // Write data ready
  output logic [1:0] S_AXI_BRESP,         // Write response
  output logic S_AXI_BVALID,              // Write response valid
  input wire logic S_AXI_BREADY,          // Write response ready
  input wire logic [11:0] S_AXI_ARADDR,   // Read address
  input wire logic S_AXI_ARVALID,         // Read address valid
  output logic S_AXI_ARREADY,             // Read address ready
  output logic [31:0] S_AXI_RDATA,        // Read data
  output logic [1:0] S_AXI_RRESP,         // Read response
  output logic S_AXI_RVALID,              // Read response valid
  input wire logic S_AXI_RREADY           // Read response ready
);

  // ==========================================================
  // Alignment check on the core data path
  // ==========================================================
  // Check enable lives with the registers further down
  logic align_en_r;
  logic misaligned;
  logic write_allow;

  tsf_align_check u_align
  (
    .enable_i(align_en_r),
    .valid_i(MEM_VALID_I),
    .word_i(MEM_WORD_I),
    .write_i(MEM_WRITE_I),
    .addr_lsb_i(MEM_ADDR_I[0]),
    .misaligned_o(misaligned),
    .write_allow_o(write_allow)
  );

  // Strobe is combinational so the suppression lands in the same cycle;
  // a registered strobe would let the faulting write reach memory first
  assign MEM_WRITE_EN_O = write_allow;
  // Fault is seen by the core now and by the flag one edge later
  assign ADDR_FAULT_O = misaligned;

  // ==========================================================
  // AXI4-Lite write channel
  // ==========================================================
  // Halves of a write that arrived one at a time
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;

  // Address and data taken in either order, one write in flight
  assign S_AXI_AWREADY = ~aw_held_r & ~bvalid_r;
  assign S_AXI_WREADY = ~w_held_r & ~bvalid_r;
  wire aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_fire = S_AXI_WVALID & S_AXI_WREADY;
  wire aw_have = aw_held_r | aw_fire;
  wire w_have = w_held_r | w_fire;
  wire [11:0] wr_addr = aw_held_r ? aw_addr_r : S_AXI_AWADDR;
  wire [31:0] wr_data = w_held_r ? w_data_r : S_AXI_WDATA;
  wire [3:0] wr_strb = w_held_r ? w_strb_r : S_AXI_WSTRB;
  // Commit waits for a free response slot, so a slow BREADY stalls
  wire wr_commit = aw_have & w_have & ~bvalid_r;

  // Address decode shared by both channels
  // Word compare: the two byte-offset bits never select a register
  function automatic logic [1:0] tsf_decode(input logic [11:0] a);
    tsf_decode[0] = ({a[11:2], 2'b00} == `TSF_STATUS_OFFSET);
    tsf_decode[1] = ({a[11:2], 2'b00} == `TSF_ALIGN_CTL_OFFSET);
  endfunction

  wire [1:0] wr_sel = tsf_decode(wr_addr);
  wire wr_status = wr_commit & wr_sel[0];
  wire wr_ctl = wr_commit & wr_sel[1] & wr_strb[0];
  wire wr_mapped = |wr_sel;

  // Address half held until its data partner arrives
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
    end
    else
    begin
      aw_held_r <= aw_have & ~wr_commit;
      if (aw_fire)
        aw_addr_r <= S_AXI_AWADDR;
    end
  end

  // Data half and its strobes held until the address arrives
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else
    begin
      w_held_r <= w_have & ~wr_commit;
      if (w_fire)
      begin
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
    end
  end

  // Response follows the commit by one cycle
  // BRESP is registered so it stands with BVALID until taken
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      bvalid_r <= 1'b0;
      S_AXI_BRESP <= `TSF_RESP_OKAY;
    end
    else if (wr_commit)
    begin
      bvalid_r <= 1'b1;
      S_AXI_BRESP <= wr_mapped ? `TSF_RESP_OKAY : `TSF_RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      bvalid_r <= 1'b0;
  end
  assign S_AXI_BVALID = bvalid_r;

  // ==========================================================
  // Trap flags
  // ==========================================================
  // Flag word with one bit per trap source
  tsf_pkg::tsf_word_t flags_r;
  tsf_pkg::tsf_word_t flags_nxt;
  tsf_pkg::tsf_word_t set_vec;
  tsf_pkg::tsf_word_t clr_vec;

  // Events per bit; the divide cause is only meaningful with a math trap
  // A source held high sets its flag again each cycle
  always_comb
  begin
    set_vec = `TSF_STATUS_RESET;
    set_vec[`TSF_BIT_DIV0] = TRAP_MATH_I & TRAP_DIV0_I;
    set_vec[`TSF_BIT_DMA] = TRAP_DMA_I;
    set_vec[`TSF_BIT_MATH] = TRAP_MATH_I;
    set_vec[`TSF_BIT_ADDR] = TRAP_ADDR_I | misaligned;
    set_vec[`TSF_BIT_STACK] = TRAP_STACK_I;
    set_vec[`TSF_BIT_OSC] = TRAP_OSC_I;
  end

  // Software clears by writing zero to a flag in byte lane 0
  // Upper lanes never clear, so a wide partial write is harmless
  always_comb
  begin
    clr_vec = `TSF_STATUS_RESET;
    if (wr_status & wr_strb[0])
      clr_vec[`TSF_FLAG_HI:`TSF_FLAG_LO] = ~wr_data[`TSF_FLAG_HI:`TSF_FLAG_LO];
  end

  // Set beats clear so a trap in the clearing cycle is kept
  always_comb
  begin
    flags_nxt = (flags_r & ~clr_vec) | set_vec;
    // Unused bits forced low so they can never read back set
    flags_nxt[`TSF_BIT_UNUSED] = 1'b0;
    flags_nxt[15:`TSF_FLAG_HI+1] = '0;
  end

  // Flags sticky across cycles, zero on reset
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
      flags_r <= `TSF_STATUS_RESET;
    else
      flags_r <= flags_nxt;
  end
  assign STATUS_O = flags_r;

  // Alignment check enable, on by default
  // Software may turn it off to run code that relies on odd words
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
      align_en_r <= `TSF_ALIGN_CTL_RESET;
    else if (wr_ctl)
      align_en_r <= wr_data[0];
  end

  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  tsf_pkg::tsf_rd_state_t rd_state_r;
  wire [1:0] rd_sel = tsf_decode(S_AXI_ARADDR);
  wire rd_mapped = |rd_sel;
  wire ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;
  // Unused bits of each register read as zero
  wire [31:0] status_rd_word = {16'h0000, flags_r};
  wire [31:0] ctl_rd_word = {31'h0, align_en_r};
  wire [31:0] rd_word = rd_sel[0] ? status_rd_word :
                        rd_sel[1] ? ctl_rd_word : 32'h0000_0000;

  // One read in flight: the address is refused while the answer waits
  assign S_AXI_ARREADY = (rd_state_r == tsf_pkg::TSF_RD_IDLE);
  assign S_AXI_RVALID = (rd_state_r == tsf_pkg::TSF_RD_RESP);

  // Data captured at address accept, so it cannot shift while waiting
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rd_state_r <= tsf_pkg::TSF_RD_IDLE;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `TSF_RESP_OKAY;
    end
    else
    begin
      case (rd_state_r)
        // Idle: data latched as the address is taken
        tsf_pkg::TSF_RD_IDLE:
        begin
          if (ar_fire)
          begin
            rd_state_r <= tsf_pkg::TSF_RD_RESP;
            S_AXI_RDATA <= rd_word;
            S_AXI_RRESP <= rd_mapped ? `TSF_RESP_OKAY : `TSF_RESP_SLVERR;
          end
        end
        // Answer: data stands until the master takes it
        tsf_pkg::TSF_RD_RESP:
        begin
          if (S_AXI_RREADY)
            rd_state_r <= tsf_pkg::TSF_RD_IDLE;
        end
        default:
          rd_state_r <= tsf_pkg::TSF_RD_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== verif/tsf_top_monitor.sv
// Port checker for the trap status block
`timescale 1ns/1ps
`default_nettype none
module tsf_top_monitor
(
  input wire logic CLK_SYS_I, // Clock
  input wire logic RST_I, // Reset
  input wire logic TRAP_MATH_I, // Math
  input wire logic TRAP_DIV0_I, // Cause
  input wire logic TRAP_DMA_I, // DMA
  input wire logic TRAP_STACK_I, // Stack
  input wire logic TRAP_OSC_I, // Oscillator
  input wire logic TRAP_ADDR_I, // Addr
  input wire logic MEM_VALID_I, // Access
  input wire logic MEM_WORD_I, // Word
  input wire logic MEM_WRITE_I, // Write
  input wire logic [15:0] MEM_ADDR_I, // Address
  input wire logic MEM_WRITE_EN_O, // Strobe
  input wire logic ADDR_FAULT_O, // Fault
  input wire logic [15:0] STATUS_O, // Flags
  input wire logic [11:0] S_AXI_ARADDR, // AR address
  input wire logic S_AXI_ARVALID, // AR valid
  input wire logic S_AXI_ARREADY, // AR ready
  input wire logic S_AXI_BVALID, // B valid
  input wire logic S_AXI_RVALID, // R valid
  input wire logic [31:0] S_AXI_RDATA // R data
);
  // ====
  // Flag and fault relations, one clock domain
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  property p_div0; TRAP_MATH_I && TRAP_DIV0_I |=> STATUS_O[6]; endproperty
  a_div0: assert property (p_div0) else $error("divide flag missed");
  property p_dma; TRAP_DMA_I |=> STATUS_O[5]; endproperty
  a_dma: assert property (p_dma) else $error("dma flag missed");
  property p_math; TRAP_MATH_I |=> STATUS_O[4]; endproperty
  a_math: assert property (p_math) else $error("math flag missed");
  property p_addr; TRAP_ADDR_I |=> STATUS_O[3]; endproperty
  a_addr: assert property (p_addr) else $error("address flag missed");
  property p_stack; TRAP_STACK_I |=> STATUS_O[2]; endproperty
  a_stack: assert property (p_stack) else $error("stack flag missed");
  property p_osc; TRAP_OSC_I |=> STATUS_O[1]; endproperty
  a_osc: assert property (p_osc) else $error("oscillator flag missed");
  // Only a status read is held to bit 0; the enable word owns its bit 0
  property p_bit0;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[11:2] == 10'h000 |=> !S_AXI_RDATA[0];
  endproperty
  a_bit0: assert property (p_bit0) else $error("bit zero set");
  property p_unused; !STATUS_O[0] && STATUS_O[15:7] == 9'h000; endproperty
  a_unused: assert property (p_unused) else $error("unused flag bit set");
  property p_mis; ADDR_FAULT_O |-> MEM_VALID_I && MEM_WORD_I && MEM_ADDR_I[0] ##1 STATUS_O[3];
  endproperty
  a_mis: assert property (p_mis) else $error("bad fault");
  property p_wsup; MEM_VALID_I && MEM_WRITE_I |-> MEM_WRITE_EN_O != ADDR_FAULT_O; endproperty
  a_wsup: assert property (p_wsup) else $error("write gate wrong");
  // A flag may only drop with a completed register write
  property p_stick; |($past(STATUS_O) & ~STATUS_O) |-> $rose(S_AXI_BVALID); endproperty
  a_stick: assert property (p_stick) else $error("flag lost");
  c_wr: cover property (S_AXI_BVALID);
  c_fault: cover property (ADDR_FAULT_O);
  c_all: cover property (STATUS_O[6:1] == 6'h3f);
endmodule
bind tsf_top tsf_top_monitor i_mon
(
  .CLK_SYS_I(CLK_SYS_I),
  .RST_I(RST_I),
  .TRAP_MATH_I(TRAP_MATH_I),
  .TRAP_DIV0_I(TRAP_DIV0_I),
  .TRAP_DMA_I(TRAP_DMA_I),
  .TRAP_STACK_I(TRAP_STACK_I),
  .TRAP_OSC_I(TRAP_OSC_I),
  .TRAP_ADDR_I(TRAP_ADDR_I),
  .MEM_VALID_I(MEM_VALID_I),
  .MEM_WORD_I(MEM_WORD_I),
  .MEM_WRITE_I(MEM_WRITE_I),
  .MEM_ADDR_I(MEM_ADDR_I),
  .MEM_WRITE_EN_O(MEM_WRITE_EN_O),
  .ADDR_FAULT_O(ADDR_FAULT_O),
  .STATUS_O(STATUS_O),
  .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RDATA(S_AXI_RDATA)
);
`default_nettype wire

// ===== verif/tsf_core_model.sv
// Core side model: trap sources and data accesses
`timescale 1ns/1ps
`default_nettype none
module tsf_core_model
(
  input wire logic clk_i, // Clock
  output logic math_o, // Math trap
  output logic div0_o, // Divide cause
  output logic dma_o, // DMA trap
  output logic stack_o, // Stack trap
  output logic osc_o, // Osc fail
  output logic addr_o, // Addr trap
  output logic valid_o, // Access
  output logic word_o, // Word
  output logic write_o, // Write
  output logic [15:0] ea_o // Address
);
  // ====
  // Bit n of trap_r is the source of flag n; bit 6 is a divide math trap
  logic [6:1] trap_r = 6'h00;
  logic [2:0] acc_r = 3'h0;
  logic [15:0] ea_r = 16'h0;
  assign {osc_o, stack_o, addr_o} = {trap_r[1], trap_r[2], trap_r[3]};
  assign {dma_o, div0_o} = {trap_r[5], trap_r[6]};
  assign math_o = trap_r[4] | trap_r[6];
  assign {valid_o, word_o, write_o} = acc_r;
  assign ea_o = ea_r;
  // One-cycle trap pulse
  task automatic fire(input logic [6:1] m);
    @(posedge clk_i);
    trap_r <= m;
    @(posedge clk_i);
    trap_r <= 6'h00;
  endtask
  // Idle address toggles so a stale value never looks valid
  task automatic drive(input logic [2:0] c, input logic [15:0] a);
    @(posedge clk_i);
    acc_r <= c;
    ea_r <= c[2] ? a : ~ea_r;
  endtask
endmodule
`default_nettype wire

// ===== verif/trap_status_flags_tb_top.sv
// Self-checking bench for the trap status block
`timescale 1ns/1ps
`default_nettype none
module trap_status_flags_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, wen, fault;
  logic math, div0, dma, stack, osc, addr, valid, word, write;
  logic [1:0] bresp, rresp;
  logic [15:0] status, ea;
  logic [6:0] m;
  logic [33:0] exp_q[$];
  logic [33:0] mem_q[$];
  logic [3:0] wstrb = 4'h1;
  int mismatches = 0, compares = 0, cycles = 0, seed = 91789;
  always #2 clk = ~clk;
  tsf_core_model i_core (.clk_i(clk), .math_o(math), .div0_o(div0), .dma_o(dma),
    .stack_o(stack), .osc_o(osc), .addr_o(addr), .valid_o(valid), .word_o(word),
    .write_o(write), .ea_o(ea));
  tsf_top i_dut (.CLK_SYS_I(clk), .RST_I(rst), .TRAP_MATH_I(math), .TRAP_DIV0_I(div0),
    .TRAP_DMA_I(dma), .TRAP_STACK_I(stack), .TRAP_OSC_I(osc), .TRAP_ADDR_I(addr),
    .MEM_VALID_I(valid), .MEM_WORD_I(word), .MEM_WRITE_I(write), .MEM_ADDR_I(ea),
    .MEM_WRITE_EN_O(wen), .ADDR_FAULT_O(fault), .STATUS_O(status), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  // ====
  // Comparison, verdict and bus tasks
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    compares++;
    if (seen !== want)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    exp_q.push_back({e, 32'h0});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // Responses checked in order against the noted expectations
  always @(posedge clk)
  begin
    if (bvalid && bready) check({bresp, 32'h0}, exp_q.pop_front());
    if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
  end
  // Core path answers are looked at mid-cycle, while the access stands
  always @(negedge clk)
  begin
    if (valid === 1'b1) check({32'h0, fault, wen}, mem_q.pop_front());
  end
  // Hang guard; the run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(12'h000, 34'h0);
    rd(12'h004, 34'h1);
    // Each source alone; a divide trap also marks a math trap
    for (int k = 1; k <= 6; k++)
    begin
      wr(12'h000, 32'h0, 2'h0);
      m = 7'h1 << k;
      i_core.fire(m[6:1]);
      m = m | (m[6] ? 7'h10 : 7'h00);
      rd(12'h000, {27'h0, m});
    end
    // Ones leave flags alone; random zeros clear
    i_core.fire(6'h3f);
    // Zeros on upper lanes only must not clear anything
    wstrb <= 4'he;
    wr(12'h000, 32'h0, 2'h0);
    wstrb <= 4'h1;
    wr(12'h000, 32'hffff_ffff, 2'h0);
    rd(12'h000, {2'h0, 32'h7e});
    r = $random(seed);
    wr(12'h000, r, 2'h0);
    rd(12'h000, {2'h0, 32'h7e & r});
    wr(12'h008, r, 2'h2);
    rd(12'h008, {2'h2, 32'h0});
    // Misaligned word, aligned word, odd byte write
    wr(12'h000, 32'h0, 2'h0);
    for (int k = 0; k < 3; k++)
    begin
      mem_q.push_back({32'h0, k == 0, k != 0});
      i_core.drive({1'b1, k != 2, 1'b1}, {r[15:1], k != 1});
      i_core.drive(3'h0, 16'h0);
    end
    rd(12'h000, {2'h0, 32'h8});
    // Check turned off: an odd word write passes and sets no flag
    wr(12'h000, 32'h0, 2'h0);
    wr(12'h004, 32'h0, 2'h0);
    rd(12'h004, 34'h0);
    mem_q.push_back({32'h0, 1'b0, 1'b1});
    i_core.drive(3'h7, {r[15:1], 1'b1});
    i_core.drive(3'h0, 16'h0);
    rd(12'h000, 34'h0);
    // Mid-run reset clears every flag and turns the check back on
    i_core.fire(6'h3f);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(12'h000, 34'h0);
    rd(12'h004, 34'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
